// ==== logic/jio_exec.sv ====
// Execute unit for jump, increment (with optional skip) and inclusive OR.
// Assumes the register file answers file_rdata combinationally for file_raddr,
// and the fetch unit takes pc_load/pc_next and flush_prefetch in the same cycle.
// Contract
// - Word 10 1kkk kkkk kkkk is an absolute jump, immediate in low eleven bits.
// - Jump loads the eleven-bit immediate into program counter bits 10..0.
// - Jump fills upper program counter bits from high latch bits 4..3.
// - Jump takes two cycles, prefetched word dropped, flags untouched.
// - Increment-skip adds one, routes by destination bit, changes no flag.
// - Increment-skip with zero result discards prefetch and runs an idle slot.
// - Increment adds one in one cycle, routes by destination bit, updates zero.
// - OR-literal ORs accumulator with literal into accumulator, updates zero.
// - OR-file ORs accumulator with file register, routes by destination, updates zero.
`timescale 1ns/100ps
`default_nettype none
module jio_exec
  import jio_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  input  wire logic                            instr_valid,
  input  wire logic [jio_pkg::IW_W-1:0]        instr,
  input  wire logic [jio_pkg::DATA_W-1:0]      pc_high_latch,
  input  wire logic [jio_pkg::DATA_W-1:0]      file_rdata,
  output logic      [jio_pkg::FADDR_W-1:0]     file_raddr,
  output jio_pkg::jio_fwrite_t                 file_wr,
  output logic      [jio_pkg::DATA_W-1:0]      acc,
  output logic                                 zero_flag,
  output logic                                 pc_load,
  output logic      [jio_pkg::PC_W-1:0]        pc_next,
  output logic                                 flush_prefetch,
  output logic                                 idle_slot
);
  import jio_pkg::*;

  function automatic jio_op_t decode(input logic [IW_W-1:0] w);
    if (w[13:11] == JMP_OPC)
      return JIO_OP_JUMP;
    else if (w[13:8] == INCSKIP_OPC)
      return JIO_OP_INCSKIP;
    else if (w[13:8] == INCREMENT_FILE_REG_OPC)
      return JIO_OP_INCREMENT_FILE_REG;
    else if (w[13:8] == ORLIT_OPC)
      return JIO_OP_ORLIT;
    else if (w[13:8] == ORFILE_OPC)
      return JIO_OP_ORFILE;
    else
      return JIO_OP_NONE;
  endfunction : decode

  jio_op_t               op;
  logic                  dest_file;
  logic [DATA_W-1:0]     result;
  logic                  kill_q;
  logic                  live;
  logic                  res_zero;
  logic                  wr_acc;

  // The slicing below is wired to the 14-bit word; other layouts are refused
  if (IW_W != 14 || DATA_W != 8 || FADDR_W != 7 || JMP_IMM_W != 11) begin : g_layout_check
    $error("jio_exec needs the 14-bit word layout");
  end
  if (PC_W != JMP_IMM_W + PC_HIGH_LATCH_HI - PC_HIGH_LATCH_LO + 1) begin : g_pc_check
    $error("program counter width does not match the jump fields");
  end
  if (DEST_BIT != FADDR_W || LIT_W != DATA_W) begin : g_field_check
    $error("destination bit or literal field misplaced");
  end

  // A killed slot is executed as an idle slot: nothing it decodes takes effect
  assign live       = instr_valid && !kill_q;
  assign op         = live ? decode(instr) : JIO_OP_NONE;
  assign dest_file  = instr[DEST_BIT];
  assign file_raddr = instr[FADDR_W-1:0];
  assign idle_slot  = instr_valid && kill_q;

  always_comb begin
    case (op)
      JIO_OP_INCSKIP, JIO_OP_INCREMENT_FILE_REG: result = DATA_W'(file_rdata + 8'h01);
      JIO_OP_ORLIT:                result = acc | instr[LIT_W-1:0];
      JIO_OP_ORFILE:               result = acc | file_rdata;
      default:                     result = '0;
    endcase
  end

  assign res_zero = (result == '0);

  always_comb begin
    file_wr.we   = 1'b0;
    file_wr.addr = instr[FADDR_W-1:0];
    file_wr.data = result;
    wr_acc       = 1'b0;
    case (op)
      JIO_OP_INCSKIP, JIO_OP_INCREMENT_FILE_REG, JIO_OP_ORFILE: begin
        file_wr.we = dest_file;
        wr_acc     = !dest_file;
      end
      JIO_OP_ORLIT: wr_acc = 1'b1;
      default: wr_acc = 1'b0;
    endcase
  end

  // Jump target is combinational so fetch can redirect in the executing cycle
  assign pc_load        = (op == JIO_OP_JUMP);
  assign pc_next        = {pc_high_latch[PC_HIGH_LATCH_HI:PC_HIGH_LATCH_LO], instr[JMP_IMM_W-1:0]};
  assign flush_prefetch = (op == JIO_OP_JUMP) || (op == JIO_OP_INCSKIP && res_zero);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      acc <= ACC_RST;
    else if (wr_acc)
      acc <= result;
  end

  // Increment-skip and jump leave the flag alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      zero_flag <= 1'b0;
    else if (op == JIO_OP_INCREMENT_FILE_REG || op == JIO_OP_ORLIT || op == JIO_OP_ORFILE)
      zero_flag <= res_zero;
  end

  // Kill waits for the next valid word, so a fetch gap cannot lose the discard
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      kill_q <= 1'b0;
    else if (instr_valid)
      kill_q <= flush_prefetch;
  end

  a_jump_target: assert property (@(posedge clk) disable iff (!reset_n)
    pc_load |-> pc_next[10:0] == instr[10:0])
    else $error("jump target low bits wrong");
  a_jump_upper: assert property (@(posedge clk) disable iff (!reset_n)
    pc_load |-> pc_next[12:11] == pc_high_latch[4:3])
    else $error("jump upper bits wrong");
  a_jump_kills: assert property (@(posedge clk) disable iff (!reset_n)
    pc_load ##1 instr_valid |-> idle_slot && !pc_load && $stable(zero_flag))
    else $error("jump did not idle next slot");
  a_skip_noflag: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCSKIP) |=> $stable(zero_flag))
    else $error("increment skip changed zero flag");
  a_skip_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCSKIP && file_rdata == 8'hFF) ##1 instr_valid |-> idle_slot)
    else $error("skip on zero did not idle");
  a_increment_file_reg_dest: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCREMENT_FILE_REG && !dest_file) |=> acc == $past(file_rdata) + 8'h01 && zero_flag == (acc == 8'h00))
    else $error("increment to accumulator wrong");
  a_orlit_acc: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_ORLIT) |=> acc == ($past(acc) | $past(instr[7:0])))
    else $error("or literal wrong");
  a_orfile_dest: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_ORFILE && dest_file) |-> file_wr.we && file_wr.data == (acc | file_rdata))
    else $error("or file writeback wrong");
  a_zero_rule: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_ORFILE) |=> zero_flag == ($past(result) == 8'h00))
    else $error("zero flag wrong");
  a_inc_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCREMENT_FILE_REG && file_rdata == 8'hFF) |-> result == 8'h00)
    else $error("increment did not wrap");

  // Jump and the idle slot that follows it
  a_jump_decode: assert property (@(posedge clk) disable iff (!reset_n)
    (instr_valid && !idle_slot) |-> pc_load == (instr[13:11] == JMP_OPC))
    else $error("jump decode wrong");
  a_jump_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    pc_load |-> flush_prefetch && !file_wr.we)
    else $error("jump wrote or did not flush");
  a_jump_holds: assert property (@(posedge clk) disable iff (!reset_n)
    pc_load |=> $stable(zero_flag) && $stable(acc))
    else $error("jump changed state");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    idle_slot |-> !file_wr.we && !pc_load && !flush_prefetch)
    else $error("idle slot took effect");
  a_idle_holds: assert property (@(posedge clk) disable iff (!reset_n)
    idle_slot |=> $stable(acc) && $stable(zero_flag))
    else $error("idle slot changed state");

  // Increment paths; skip leaves the flag, plain increment sets it
  a_skip_route: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCSKIP) |-> file_wr.we == dest_file && file_wr.data == 8'(file_rdata + 8'h01))
    else $error("increment skip routing wrong");
  a_skip_acc: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCSKIP && !dest_file) |=> acc == 8'($past(file_rdata) + 8'h01))
    else $error("increment skip to accumulator wrong");
  a_skip_file: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCSKIP && dest_file) |=> $stable(acc))
    else $error("increment skip to file changed accumulator");
  a_skip_nonzero: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCSKIP && file_rdata != 8'hFF) |-> !flush_prefetch)
    else $error("skip without zero result");
  a_increment_file_reg_file: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCREMENT_FILE_REG && dest_file) |-> file_wr.we && file_wr.data == 8'(file_rdata + 8'h01))
    else $error("increment to file wrong");
  a_increment_file_reg_keep: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCREMENT_FILE_REG && dest_file) |=> $stable(acc))
    else $error("increment to file changed accumulator");
  a_increment_file_reg_single: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCREMENT_FILE_REG) |-> !flush_prefetch && !pc_load)
    else $error("increment took more than one cycle");
  a_inc_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_INCREMENT_FILE_REG) |=> zero_flag == ($past(file_rdata) == 8'hFF))
    else $error("increment zero flag wrong");

  // OR paths and the shared file address
  a_orlit_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_ORLIT) |=> zero_flag == (acc == 8'h00))
    else $error("or literal zero flag wrong");
  a_orlit_route: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_ORLIT) |-> !file_wr.we && !flush_prefetch && !pc_load)
    else $error("or literal routing wrong");
  a_orfile_acc: assert property (@(posedge clk) disable iff (!reset_n)
    (op == JIO_OP_ORFILE && !dest_file) |=> acc == ($past(acc) | $past(file_rdata)))
    else $error("or file to accumulator wrong");
  a_write_addr: assert property (@(posedge clk) disable iff (!reset_n)
    file_wr.we |-> file_wr.addr == instr[6:0] && file_raddr == instr[6:0])
    else $error("file address wrong");

  c_jump:    cover property (@(posedge clk) disable iff (!reset_n) pc_load ##1 idle_slot);
  c_skip:    cover property (@(posedge clk) disable iff (!reset_n) op == JIO_OP_INCSKIP && res_zero);
  c_orfile:  cover property (@(posedge clk) disable iff (!reset_n) op == JIO_OP_ORFILE && dest_file);
  c_inc_wrap: cover property (@(posedge clk) disable iff (!reset_n) op == JIO_OP_INCREMENT_FILE_REG && file_rdata == 8'hFF);
  c_idle_gap: cover property (@(posedge clk) disable iff (!reset_n) flush_prefetch ##1 !instr_valid ##1 idle_slot);
endmodule : jio_exec
`default_nettype wire

// ==== include/jio_pkg.sv ====
// Constants and carrier types for the jump, increment and OR execute unit.
// Assumes a 14-bit instruction word presented one per instruction cycle.
package jio_pkg;
  localparam int IW_W         = 14;
  localparam int DATA_W       = 8;
  localparam int FADDR_W      = 7;
  localparam int PC_W         = 13;
  localparam int JMP_IMM_W    = 11;
  localparam int LIT_W        = 8;
  localparam int DEST_BIT     = 7;
  localparam int PC_HIGH_LATCH_HI    = 4;
  localparam int PC_HIGH_LATCH_LO    = 3;
  localparam logic [2:0] JMP_OPC     = 3'h5;
  localparam logic [5:0] INCSKIP_OPC = 6'h0F;
  localparam logic [5:0] INCREMENT_FILE_REG_OPC    = 6'h0A;
  localparam logic [5:0] ORLIT_OPC   = 6'h38;
  localparam logic [5:0] ORFILE_OPC  = 6'h04;
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;

  typedef enum logic [2:0] {
    JIO_OP_NONE,
    JIO_OP_JUMP,
    JIO_OP_INCSKIP,
    JIO_OP_INCREMENT_FILE_REG,
    JIO_OP_ORLIT,
    JIO_OP_ORFILE
  } jio_op_t;

  typedef struct packed {
    logic                 we;
    logic [FADDR_W-1:0]   addr;
    logic [DATA_W-1:0]    data;
  } jio_fwrite_t;
endpackage : jio_pkg

// ==== verification/tb_top.sv ====
// Self-checking bench for the jump, increment and OR execute unit.
// Assumes jio_exec and jio_pkg; the bench plays the fetch unit and register file.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import jio_pkg::*;
  typedef struct packed {
    logic [7:0]  acc;
    logic        zf;
    logic        ld;
    logic [12:0] pc;
    logic        fl;
    logic        idl;
    logic [15:0] wr;
  } jio_note_t;
  logic        clk = 0, reset_n = 0, instr_valid = 0;
  logic [13:0] instr = 0;
  logic [7:0]  pc_high_latch = 0, file_rdata = 0, acc, m_acc = 0, r;
  logic [6:0]  file_raddr;
  logic [12:0] pc_next;
  logic        zero_flag, pc_load, flush_prefetch, idle_slot, m_z = 0, m_kill = 0;
  jio_fwrite_t file_wr;
  jio_note_t   q[$], n, mn;
  int          miscompares = 0, checks_done = 0, sel;
  jio_exec i_jio_exec(.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
    .pc_high_latch(pc_high_latch), .file_rdata(file_rdata), .file_raddr(file_raddr), .file_wr(file_wr),
    .acc(acc), .zero_flag(zero_flag), .pc_load(pc_load), .pc_next(pc_next),
    .flush_prefetch(flush_prefetch), .idle_slot(idle_slot));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Reference model runs in the driver; the kill state survives idle cycles
  task automatic issue(input logic [13:0] w, input logic [7:0] f, input logic v);
    @(posedge clk);
    #1;
    instr_valid = v;
    instr = w;
    file_rdata = f;
    pc_high_latch = 8'($urandom);
    if (!v) return;
    n = '{m_acc, m_z, 1'b0, {pc_high_latch[4:3], w[10:0]}, 1'b0, m_kill, 16'h0000};
    if (m_kill) m_kill = 0;
    else if (w[13:11] == JMP_OPC) begin
      n.ld = 1;
      n.fl = 1;
      m_kill = 1;
    end else if (w[13:8] == ORLIT_OPC) begin
      m_acc = m_acc | w[7:0];
      m_z = (m_acc == 8'h00);
    end else if (w[13:8] inside {INCSKIP_OPC, INCREMENT_FILE_REG_OPC, ORFILE_OPC}) begin
      r = (w[13:8] == ORFILE_OPC) ? (m_acc | f) : 8'(f + 8'h01);
      if (w[7]) n.wr = {1'b1, w[6:0], r};
      else m_acc = r;
      if (w[13:8] != INCSKIP_OPC) m_z = (r == 8'h00);
      else if (r == 8'h00) begin
        n.fl = 1;
        m_kill = 1;
      end
    end
    q.push_back(n);
  endtask : issue
  always @(negedge clk) begin
    if (reset_n && instr_valid) begin
      mn = q.pop_front();
      check({8'h00, acc}, {8'h00, mn.acc});
      check({15'h0000, zero_flag}, {15'h0000, mn.zf});
      check({2'h0, pc_load, pc_next}, {2'h0, mn.ld, mn.pc});
      check({14'h0000, flush_prefetch, idle_slot}, {14'h0000, mn.fl, mn.idl});
      check({15'h0000, file_wr.we}, {15'h0000, mn.wr[15]});
      if (mn.wr[15]) check(file_wr, mn.wr);
      check({9'h000, file_raddr}, {9'h000, instr[6:0]});
    end
  end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial begin
    void'($urandom(56875));
    repeat (8) @(posedge clk);
    #1 reset_n = 1;
    // Jump, skip over a zero increment with one idle cycle in between, then increments mixed with ORs
    issue(14'h2ABC, 8'h00, 1);
    issue(14'h3812, 8'h00, 1);
    issue(14'h0FA5, 8'hFF, 1);
    issue(14'h3812, 8'h00, 0);
    issue(14'h3812, 8'h00, 1);
    issue(14'h0A05, 8'h99, 1);
    issue(14'h3835, 8'h00, 1);
    issue(14'h0A85, 8'hFF, 1);
    issue(14'h0413, 8'h13, 1);
    issue(14'h0000, 8'h00, 1);
    $display("directed test done");
    repeat (600) begin
      sel = $urandom % 6;
      n.wr = 16'($urandom);
      case (sel)
        0: n.wr[13:11] = JMP_OPC;
        1: n.wr[13:8] = INCSKIP_OPC;
        2: n.wr[13:8] = INCREMENT_FILE_REG_OPC;
        3: n.wr[13:8] = ORLIT_OPC;
        4: n.wr[13:8] = ORFILE_OPC;
        default: n.wr[13:8] = 6'h3F;
      endcase
      issue(n.wr[13:0], ($urandom % 3 == 0) ? 8'hFF : 8'($urandom), ($urandom % 4) != 0);
    end
    issue(14'h0000, 8'h00, 1);
    $display("random test done");
    // Reset in mid-run must clear state; the word before it (14'h2000) is not a jump, so no kill is pending
    issue(14'h2000, 8'h00, 1);
    @(negedge clk);
    #1 reset_n = 0;
    instr_valid = 0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1;
    m_acc = 0;
    m_z = 0;
    m_kill = 0;
    issue(14'h0000, 8'h00, 1);
    @(posedge clk);
    $display("reset test done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
